//--- logic/ccp_channel.sv
// Capture/compare/PWM channel with register port, dead time and shutdown.
//
// Added by the designer: the register addresses and the plain strobed port.
`default_nettype none
module ccp_channel (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [47:0] timer_count_value_i,
  input wire logic [2:0] timer_tick_i,
  input wire logic [2:0] timer_clock_i,
  input wire logic [2:0] timer_output_i,
  input wire logic [2:0] timer_underflow_event_i,
  input wire logic [2:0] timer_overflow_event_i,
  input wire logic [2:0] timer_ext_reset_i,
  input wire logic capture_pin_i,
  input wire logic comparator_zero_i,
  input wire logic halt_ext_i,
  output logic pwm_out_high_side_o,
  output logic pwm_out_low_side_o,
  output logic irq_o
);
  logic [31:0] cfg;
  logic [4:0] sts;
  logic [15:0] sdcfg;
  logic [16:0] data_reg;
  logic [16:0] hold;
  logic [31:0] rdata;
  logic cap_q;
  logic sd_q;
  logic sd_active;
  logic [7:0] mask_cnt;
  logic [1:0] ph;
  logic [1:0] pl;

  // Address decode of the register port.
  wire sel_cfg = (addr_i == ccp_pkg::ADDR_CFG);
  wire sel_sts = (addr_i == ccp_pkg::ADDR_STS);
  wire sel_data = (addr_i == ccp_pkg::ADDR_DATA);
  wire sel_sd = (addr_i == ccp_pkg::ADDR_SDCFG);
  wire wr_cfg = wr_i & sel_cfg;
  wire wr_sts = wr_i & sel_sts;
  wire wr_data = wr_i & sel_data;
  wire wr_sd = wr_i & sel_sd;
  wire rd_data = rd_i & sel_data;

  // Configuration fields.
  wire [1:0] tsel = cfg[ccp_pkg::CFG_TSEL_LO +: 2];
  wire [1:0] edge_f = cfg[ccp_pkg::CFG_EDGE_LO +: 2];
  wire cap_mode = cfg[ccp_pkg::CFG_MODE];
  wire [2:0] src = cfg[ccp_pkg::CFG_SRC_LO +: 3];
  wire [4:0] ien = cfg[ccp_pkg::CFG_IEN_LO +: 5];
  wire [7:0] gap = cfg[ccp_pkg::CFG_GAP_LO +: 8];
  wire sd_en = sdcfg[ccp_pkg::SD_EN];
  wire sd_hval = sdcfg[ccp_pkg::SD_HVAL];
  wire sd_lval = sdcfg[ccp_pkg::SD_LVAL];
  wire sd_auto = sdcfg[ccp_pkg::SD_AUTO];
  wire [1:0] sd_src = sdcfg[ccp_pkg::SD_SRC_LO +: 2];
  wire [1:0] sd_trig = sdcfg[ccp_pkg::SD_TRIG_LO +: 2];
  wire [7:0] sd_mask = sdcfg[ccp_pkg::SD_MASK_LO +: 8];

  // Timer attach: code 0 is off, codes 1 to 3 pick timers 0 to 2.
  wire on = (tsel != 2'h0);
  wire [1:0] ti = tsel - 2'h1;
  wire [15:0] tmr_count = timer_count_value_i[{ti, 4'h0} +: 16];
  wire t_tick = on & timer_tick_i[ti];
  wire t_under = on & timer_underflow_event_i[ti];
  wire t_over = on & timer_overflow_event_i[ti];
  wire t_rst = on & timer_ext_reset_i[ti];

  // A cycle boundary is any turning point of the counter or an external
  // timer reset. Sawtooth timers turn once per period, so outputs are edge
  // aligned; triangle timers compare on both slopes and centre align.
  wire cyc_start = t_under | t_over | t_rst;

  // Capture source: pin, invalid, then output and clock of each timer.
  wire [7:0] cap_srcs = {timer_clock_i[2], timer_output_i[2],
                         timer_clock_i[1], timer_output_i[1],
                         timer_clock_i[0], timer_output_i[0],
                         1'b0, capture_pin_i};
  wire cap_in = cap_srcs[src];
  wire cap_rise = cap_in & ~cap_q;
  wire cap_fall = ~cap_in & cap_q;
  wire cap_hit_r = cap_rise & (edge_f == ccp_pkg::CAP_RISE ||
                               edge_f == ccp_pkg::CAP_BOTH);
  wire cap_hit_f = cap_fall & (edge_f == ccp_pkg::CAP_FALL ||
                               edge_f == ccp_pkg::CAP_BOTH);
  wire cap_evt = on & cap_mode & (cap_hit_r | cap_hit_f);

  // Threshold update moment chosen by the edge field in PWM mode.
  wire upd_under = (edge_f == ccp_pkg::UPD_UNDER) |
                   (edge_f == 2'h3);
  wire upd_over = (edge_f == ccp_pkg::UPD_OVER) |
                  (edge_f == 2'h3);
  wire upd_evt = ~cap_mode & ((upd_under & t_under) |
                              (upd_over & t_over));
  wire upd_now = ~cap_mode & wr_data &
                 (edge_f == ccp_pkg::UPD_NOW);
  // An update point with no fresh value written is an underrun.
  wire underrun = upd_evt & sts[ccp_pkg::STS_EMPTY];
  wire load_hold = upd_now | (upd_evt & ~sts[ccp_pkg::STS_EMPTY]);

  // Signed compare of the zero-extended count with the threshold.
  wire signed [17:0] cnt_s = {2'b00, tmr_count};
  wire signed [17:0] thr_s = {hold[16], hold};
  wire raw_h = (cnt_s <= thr_s);

  // Shutdown source and trigger decode.
  wire sd_in = (sd_src == ccp_pkg::SDSRC_CMP) ? comparator_zero_i :
               (sd_src == ccp_pkg::SDSRC_EXT) ? halt_ext_i : 1'b0;
  wire sd_hit = (sd_trig == ccp_pkg::TRIG_LOW) ? ~sd_in :
                (sd_trig == ccp_pkg::TRIG_HIGH) ? sd_in :
                (sd_trig == ccp_pkg::TRIG_FALL) ? (~sd_in & sd_q) :
                (sd_in & ~sd_q);
  wire masked = (mask_cnt != 8'h00);
  wire sd_trip = sd_en & on & ~cap_mode & ~masked & sd_hit;
  wire auto_clr = sd_auto & cyc_start;

  // Dead gap stages, one per output polarity side.
  ccp_gap_if gif[2] ();
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_gap
      assign gif[g].tick = t_tick;
      assign gif[g].gap = gap;
      assign gif[g].req = on & ~cap_mode & ((g == 0) ? raw_h : ~raw_h);
      ccp_dead_gap u_gap (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .gp(gif[g])
      );
    end
  endgenerate

  // Independent polarity, then the shutdown override levels.
  wire pol_h = gif[0].out ^ src[0];
  wire pol_l = gif[1].out ^ src[1];
  wire pwm_run = on & ~cap_mode;
  wire next_h = ~pwm_run ? 1'b0 : sd_active ? sd_hval : pol_h;
  wire next_l = ~pwm_run ? 1'b0 : sd_active ? sd_lval : pol_l;

  // Read multiplexer; unmapped addresses answer zero.
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (sel_cfg)
      rdata = cfg;
    else if (sel_sts)
      rdata = {27'h000_0000, sts};
    else if (sel_data)
      rdata = {15'h0000, data_reg};
    else if (sel_sd)
      rdata = {16'h0000, sdcfg};
  end

  // Register writes and read data, which stand one cycle after the strobe.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg <= ccp_pkg::CFG_RESET;
      sdcfg <= ccp_pkg::SD_RESET;
      rdata_o <= 32'h0000_0000;
    end
    else
    begin
      rdata_o <= rd_i ? rdata : 32'h0000_0000;
      if (wr_cfg)
        cfg <= wdata_i & ccp_pkg::CFG_MASK;
      if (wr_sd)
        sdcfg <= wdata_i[15:0];
    end
  end

  // Data word: software writes in PWM mode, captures land in capture mode.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      data_reg <= ccp_pkg::DATA_RESET;
      hold <= ccp_pkg::DATA_RESET;
      cap_q <= 1'b0;
    end
    else
    begin
      cap_q <= cap_in;
      if (cap_evt)
        data_reg <= {cap_hit_f & ~cap_hit_r, tmr_count};
      else if (wr_data)
        data_reg <= wdata_i[16:0];
      if (upd_now)
        hold <= wdata_i[16:0];
      else if (load_hold)
        hold <= data_reg;
    end
  end

  // Status flags; every hardware set wins over a clear in the same cycle.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sts <= ccp_pkg::STS_RESET;
    else
    begin
      if (cap_evt)
        sts[ccp_pkg::STS_CFULL] <= 1'b1;
      else if (rd_data)
        sts[ccp_pkg::STS_CFULL] <= 1'b0;
      if (cap_evt && sts[ccp_pkg::STS_CFULL])
        sts[ccp_pkg::STS_COVER] <= 1'b1;
      else if (wr_sts && wdata_i[ccp_pkg::STS_COVER])
        sts[ccp_pkg::STS_COVER] <= 1'b0;
      if (load_hold && !upd_now)
        sts[ccp_pkg::STS_EMPTY] <= 1'b1;
      else if (wr_data)
        sts[ccp_pkg::STS_EMPTY] <= 1'b0;
      if (underrun)
        sts[ccp_pkg::STS_UNDER] <= 1'b1;
      else if (wr_sts && wdata_i[ccp_pkg::STS_UNDER])
        sts[ccp_pkg::STS_UNDER] <= 1'b0;
      if (sd_trip)
        sts[ccp_pkg::STS_SHDN] <= 1'b1;
      else if ((wr_sts && wdata_i[ccp_pkg::STS_SHDN]) || auto_clr)
        sts[ccp_pkg::STS_SHDN] <= 1'b0;
    end
  end

  // Shutdown state. In permanent mode it follows the flag, so only a
  // software clear releases it; in restart mode the cycle boundary does.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sd_q <= 1'b0;
      sd_active <= 1'b0;
      mask_cnt <= 8'h00;
    end
    else
    begin
      sd_q <= sd_in;
      if (sd_trip)
        sd_active <= 1'b1;
      else if (auto_clr)
        sd_active <= 1'b0;
      else if (!sd_auto && !sts[ccp_pkg::STS_SHDN])
        sd_active <= 1'b0;
      if (cyc_start)
        mask_cnt <= sd_mask;
      else if (masked && t_tick)
        mask_cnt <= mask_cnt - 8'h01;
    end
  end

  // Output flops keep the pins glitch free.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pwm_out_high_side_o <= 1'b0;
      pwm_out_low_side_o <= 1'b0;
    end
    else
    begin
      pwm_out_high_side_o <= next_h;
      pwm_out_low_side_o <= next_l;
    end
  end

  // Request line: enabled status bits gate one level output.
  assign irq_o = |(sts & ien);
endmodule
`default_nettype wire

//--- logic/ccp_dead_gap.sv
// Dead-time stage that delays rising edges by whole timer clock ticks.
`default_nettype none
module ccp_dead_gap (
  input wire logic mclk_i,
  input wire logic rstn_i,
  ccp_gap_if.gap_side gp
);
  logic req_q;
  logic [7:0] cnt;
  logic run;
  logic out_q;
  wire rise = gp.req & ~req_q;
  wire cnt_done = (cnt == 8'h00);

  // A rise reloads the count; a fall cancels any pending delay at once.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      req_q <= 1'b0;
      cnt <= 8'h00;
      run <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      req_q <= gp.req;
      if (!gp.req)
      begin
        run <= 1'b0;
        out_q <= 1'b0;
      end
      else if (rise)
      begin
        cnt <= gp.gap;
        run <= (gp.gap != 8'h00);
        out_q <= (gp.gap == 8'h00);
      end
      else if (run && gp.tick)
      begin
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01)
        begin
          run <= 1'b0;
          out_q <= 1'b1;
        end
      end
      else if (!run && cnt_done)
      begin
        out_q <= 1'b1;
      end
    end
  end

  assign gp.out = out_q;
endmodule
`default_nettype wire

//--- logic/ccp_gap_if.sv
// Signals between the channel and one dead-time gap stage.
`default_nettype none
interface ccp_gap_if;
  logic tick;
  logic [7:0] gap;
  logic req;
  logic out;
  modport ctl (output tick, output gap, output req, input out);
  modport gap_side (input tick, input gap, input req, output out);
endinterface
`default_nettype wire

//--- logic/ccp_pkg.sv
// Constants of the capture/compare/PWM channel: offsets, fields, resets.
// Summary of operation
// - Threshold is signed 17-bit, -1 to 65535.
// - Count at or below threshold drives high side.
// - Dead time delays each rising edge, 0-255.
// - Polarity bits invert high and low independently.
// - Source field picks the capture input.
// - Mode bit chooses PWM or capture.
// - Capture stores count and edge direction.
// - Edge field chooses capture trigger edges.
// - Edge field chooses threshold update moment.
// - Timer select attaches to timer or off.
// - Alignment follows the timer counting shape.
// - Five enable bits gate the interrupt.
// - Permanent shutdown holds until flag cleared.
// - Auto restart shutdown ends at next cycle.
// - Shutdown from pin or comparator, level/edge.
// - Shutdown ignored for masked cycles at start.
// - External timer reset restarts PWM cycle.
// - Status flags clear by write, write or read.
// - Trigger select: low, high, falling, rising.
// - Shutdown drives programmed levels; restart mode.
`default_nettype none
package ccp_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STS = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_SDCFG = 8'h0C;
  // Configuration field positions.
  localparam int CFG_TSEL_LO = 0;
  localparam int CFG_EDGE_LO = 2;
  localparam int CFG_MODE = 4;
  localparam int CFG_SRC_LO = 5;
  localparam int CFG_IEN_LO = 8;
  localparam int CFG_GAP_LO = 16;
  localparam logic [31:0] CFG_MASK = 32'h00FF_1FFF;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // Status bit positions.
  localparam int STS_CFULL = 0;
  localparam int STS_COVER = 1;
  localparam int STS_EMPTY = 2;
  localparam int STS_UNDER = 3;
  localparam int STS_SHDN = 4;
  localparam logic [4:0] STS_RESET = 5'h04;
  // Shutdown configuration field positions.
  localparam int SD_EN = 0;
  localparam int SD_HVAL = 1;
  localparam int SD_LVAL = 2;
  localparam int SD_AUTO = 3;
  localparam int SD_SRC_LO = 4;
  localparam int SD_TRIG_LO = 6;
  localparam int SD_MASK_LO = 8;
  localparam logic [15:0] SD_RESET = 16'h0000;
  // Field encodings.
  localparam logic [1:0] TRIG_LOW = 2'h0;
  localparam logic [1:0] TRIG_HIGH = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_RISE = 2'h3;
  localparam logic [1:0] UPD_NOW = 2'h0;
  localparam logic [1:0] UPD_UNDER = 2'h1;
  localparam logic [1:0] UPD_OVER = 2'h2;
  localparam logic [1:0] CAP_RISE = 2'h1;
  localparam logic [1:0] CAP_FALL = 2'h2;
  localparam logic [1:0] CAP_BOTH = 2'h3;
  localparam logic [2:0] SRC_PIN = 3'h0;
  localparam logic [1:0] SDSRC_CMP = 2'h0;
  localparam logic [1:0] SDSRC_EXT = 2'h1;
  localparam logic [16:0] DATA_RESET = 17'h0_0000;
endpackage
`default_nettype wire

//--- testbench/ccp_channel_assertions.sv
// Port-level checker for the capture/compare/PWM channel.
`default_nettype none
module ccp_channel_assertions (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic pwm_out_high_side_o,
  input wire logic pwm_out_low_side_o,
  input wire logic irq_o
);
  logic [31:0] cfg;
  logic [16:0] thr;
  logic [15:0] sd;
  logic [2:0] quiet;
  wire logic steady;
  wire logic h;
  wire logic l;
  // Shadow of the written settings; quiet counts cycles since any write.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg <= 32'h0000_0000;
      thr <= 17'h0_0000;
      sd <= 16'h0000;
      quiet <= 3'h0;
    end
    else
    begin
      if (wr_i && addr_i == 8'h00)
        cfg <= wdata_i & 32'h00FF_1FFF;
      if (wr_i && addr_i == 8'h08)
        thr <= wdata_i[16:0];
      if (wr_i && addr_i == 8'h0C)
        sd <= wdata_i[15:0];
      quiet <= wr_i ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
    end
  end
  // Plain PWM settled: the output pipeline needs a few cycles after a write.
  assign steady = quiet > 3'h3 && cfg[1:0] != 2'h0 && cfg[23:16] == 8'h00
    && cfg[4:2] == 3'h0 && sd == 16'h0000;
  assign h = pwm_out_high_side_o;
  assign l = pwm_out_low_side_o;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  property p_off;
    quiet > 3'h2 && cfg[1:0] == 2'h0 |-> !h && !l;
  endproperty
  a_off: assert property (p_off)
    else $error("outputs active with timer off");
  property p_capt;
    quiet > 3'h2 && cfg[4] |-> !h && !l;
  endproperty
  a_capt: assert property (p_capt)
    else $error("outputs active in capture mode");
  property p_irq;
    cfg[12:8] == 5'h00 |-> !irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt with all enables clear");
  property p_rd_zero;
    !$past(rd_i) |-> rdata_o == 32'h0000_0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("read data outside read slot");
  property p_data_w;
    $past(rd_i) && $past(addr_i) == 8'h08 |-> rdata_o[31:17] == 15'h0000;
  endproperty
  a_data_w: assert property (p_data_w)
    else $error("data read above bit 16");
  property p_cfg_back;
    $past(rd_i) && $past(addr_i) == 8'h00 |-> rdata_o == $past(cfg);
  endproperty
  a_cfg_back: assert property (p_cfg_back)
    else $error("configuration read back differs");
  property p_full;
    steady && thr == 17'h0_FFFF |-> h == !cfg[5] && l == cfg[6];
  endproperty
  a_full: assert property (p_full)
    else $error("full threshold output wrong");
  property p_neg;
    steady && thr == 17'h1_FFFF |-> h == cfg[5] && l == !cfg[6];
  endproperty
  a_neg: assert property (p_neg)
    else $error("negative threshold output wrong");
  c_data: cover property (rd_i && addr_i == 8'h08);
  c_irq: cover property (irq_o);
  c_full: cover property (steady && thr == 17'h0_FFFF);
endmodule
`default_nettype wire

//--- testbench/ccp_timer_model.sv
// Model of the three general-purpose timers that feed the channel.
`default_nettype none
module ccp_timer_model (
  input wire logic mclk_i,
  input wire logic rstn_i,
  output logic [47:0] count_o,
  output logic [2:0] tick_o,
  output logic [2:0] ovf_o
);
  logic [3:0] cnt;
  // Timer 0 is a 16-step up sawtooth, so its PWM is edge aligned.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt <= 4'h0;
    else
      cnt <= cnt + 4'h1;
  end
  // Timer 1 rests at zero; timer 2 holds a count so captures are known.
  assign count_o = {16'h1234, 16'h0000, 12'h000, cnt};
  assign tick_o = 3'h7;
  assign ovf_o = {2'h0, cnt == 4'hF};
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the capture/compare/PWM channel.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] c; logic [31:0] d; logic [7:0] h;
    logic [7:0] l;} ccp_row_t;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin = 1'b0;
  logic halt = 1'b0;
  logic hi, lo, irq;
  logic [31:0] rdata;
  logic [47:0] cnt;
  logic [2:0] tick, ovf;
  logic [7:0] nh, nl;
  int errors = 0;
  int total_checks = 0;
  // Setting, threshold, then high and low cycles over one 16-cycle period.
  ccp_row_t rows [11] = '{
    '{32'h0000_0001, 32'h0001_FFFF, 8'h00, 8'h10},
    '{32'h0000_0001, 32'h0000_FFFF, 8'h10, 8'h00},
    '{32'h0000_0061, 32'h0000_FFFF, 8'h00, 8'h10},
    '{32'h0000_0041, 32'h0000_FFFF, 8'h10, 8'h10},
    '{32'h0000_0001, 32'h0000_0005, 8'h06, 8'h0A},
    '{32'h0000_0001, 32'h0000_0000, 8'h01, 8'h0F},
    '{32'h0003_0001, 32'h0000_0005, 8'h03, 8'h07},
    '{32'h00FF_0001, 32'h0000_0005, 8'h00, 8'h00},
    '{32'h0000_0000, 32'h0000_0005, 8'h00, 8'h00},
    '{32'h0000_0002, 32'h0000_0000, 8'h10, 8'h00},
    '{32'h0000_0011, 32'h0000_0005, 8'h00, 8'h00}};
  ccp_timer_model i_tmr (.mclk_i, .rstn_i, .count_o(cnt), .tick_o(tick),
    .ovf_o(ovf));
  ccp_channel i_dut (.mclk_i, .rstn_i, .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .timer_count_value_i(cnt),
    .timer_tick_i(tick), .timer_clock_i(3'h0), .timer_output_i(3'h0),
    .timer_underflow_event_i(3'h0), .timer_overflow_event_i(ovf),
    .timer_ext_reset_i(3'h0), .capture_pin_i(pin), .comparator_zero_i(1'b0),
    .halt_ext_i(halt), .pwm_out_high_side_o(hi), .pwm_out_low_side_o(lo),
    .irq_o(irq));
  // A 100 MHz clock.
  always #5 mclk_i = ~mclk_i;
  task automatic check(input string n, input logic [31:0] s,
    input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  // Read data only stand in the cycle after the strobe, so sample mid-cycle.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
    input string n);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    @(negedge mclk_i);
    check(n, rdata, e);
  endtask
  task automatic pin_to(input logic v);
    @(posedge mclk_i);
    pin <= v;
    repeat (4) @(posedge mclk_i);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // A hung run counts as a mismatch and ends through the same report.
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    close_out();
  end
  initial
  begin
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd_chk(8'h00, 32'h0000_0000, "cfg reset");
    rd_chk(8'h04, 32'h0000_0004, "status reset");
    rd_chk(8'h08, 32'h0000_0000, "data reset");
    wr_reg(8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0000_0000, "unmapped");
    foreach (rows[i])
    begin
      wr_reg(8'h00, rows[i].c);
      wr_reg(8'h08, rows[i].d);
      repeat (20) @(negedge mclk_i);
      nh = 8'h00;
      nl = 8'h00;
      repeat (16)
      begin
        @(negedge mclk_i);
        nh = nh + {7'h00, hi};
        nl = nl + {7'h00, lo};
      end
      check("high cycles", {24'h00_0000, nh}, {24'h00_0000, rows[i].h});
      check("low cycles", {24'h00_0000, nl}, {24'h00_0000, rows[i].l});
    end
    // Rising-only capture on timer 2 must ignore the falling edge.
    wr_reg(8'h00, 32'h0000_0217);
    pin_to(1'b1);
    pin_to(1'b0);
    rd_chk(8'h04, 32'h0000_0001, "status full");
    rd_chk(8'h08, 32'h0000_1234, "capture rise");
    rd_chk(8'h04, 32'h0000_0000, "full cleared");
    wr_reg(8'h00, 32'h0000_021F);
    pin_to(1'b1);
    pin_to(1'b0);
    rd_chk(8'h04, 32'h0000_0003, "overrun");
    check("irq on", {31'h0000_0000, irq}, 32'h0000_0001);
    rd_chk(8'h08, 32'h0001_1234, "capture fall");
    wr_reg(8'h04, 32'h0000_0002);
    rd_chk(8'h04, 32'h0000_0000, "overrun cleared");
    check("irq off", {31'h0000_0000, irq}, 32'h0000_0000);
    // Permanent shutdown on a high level of the external input.
    wr_reg(8'h00, 32'h0000_0001);
    wr_reg(8'h08, 32'h0000_FFFF);
    wr_reg(8'h0C, 32'h0000_0055);
    @(posedge mclk_i);
    halt <= 1'b1;
    repeat (2) @(posedge mclk_i);
    halt <= 1'b0;
    repeat (40) @(negedge mclk_i);
    check("shut levels", {30'h0000_0000, hi, lo}, 32'h0000_0001);
    rd_chk(8'h04, 32'h0000_0010, "shut flag");
    wr_reg(8'h04, 32'h0000_0010);
    repeat (8) @(negedge mclk_i);
    check("resumed", {30'h0000_0000, hi, lo}, 32'h0000_0002);
    // Deferred update on overflow: one load empties, the next underruns.
    wr_reg(8'h00, 32'h0000_0009);
    wr_reg(8'h08, 32'h0000_0005);
    repeat (40) @(negedge mclk_i);
    rd_chk(8'h04, 32'h0000_000C, "deferred underrun");
    wr_reg(8'h04, 32'h0000_0008);
    rd_chk(8'h04, 32'h0000_0004, "underrun cleared");
    close_out();
  end
endmodule
bind ccp_channel ccp_channel_assertions i_chk (.mclk_i, .rstn_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .pwm_out_high_side_o,
  .pwm_out_low_side_o, .irq_o);
`default_nettype wire
